/* hw/msc_scale_cal.sv */
// Purpose: per-phase gain, phase-offset and meter-unit scaling datapath
// Assumes: host drives the word-indexed register port; inputs synchronous
// Notes: measurements refresh once per frame; calibration lost on reset
// Functional notes
// - rms current lsb is full-scale over 2^24
// - rms voltage lsb is full-scale over 2^24
// - energy lsb is VFS*IFS*tFR over 2^16
// - amp-hour lsb is IFS*tFR over 2^16
// - limit thresholds use full-scale over 2^16
// - four writable scaling coefficients, one per family
// - virtual read is value times coefficient
// - phase A current raw and virtual addresses
// - gain 0x4000 means unity
// - gains unsigned 1.14, host keeps msb zero
// - new gain visible within three seconds
// - calibration constants reset, host reloads them
// - power gain multiplies with voltage, current gains
// - three phase offsets chosen by current range
// - limits compare against rms bits 23:8
`timescale 1ns/1ps
module msc_scale_cal import msc_pkg::*; #(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wen,
  input wire logic reg_ren,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [31:0] meas_vrms [NPH],
  input wire logic [31:0] meas_irms [NPH],
  input wire logic [31:0] meas_p [NPH],
  input wire logic [31:0] meas_q [NPH],
  output logic frame_tick,
  output logic [NPH-1:0] over_current,
  output logic [NPH-1:0] over_voltage,
  output logic [NPH-1:0] under_voltage,
  output logic [NPH-1:0] no_load
);
  // ==========================================================
  // helpers
  function automatic logic [31:0] virt_scale(input logic [31:0] raw, input logic [15:0] cc);
    logic [47:0] prod;
    prod = raw * cc;
    virt_scale = prod[31:0];
  endfunction
  function automatic logic [15:0] thr_bits(input logic [31:0] rms);
    thr_bits = rms[THR_MSB:THR_LSB];
  endfunction

  // ==========================================================
  // frame divider
  logic [15:0] div_q;
  wire logic div_end = (div_q == 16'(FRAME_LEN - 1));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
    end
  end
  assign frame_tick = div_end;

  // ==========================================================
  // configuration registers
  logic [15:0] cal_q [NPH][6];
  logic [15:0] thr_q [6];
  logic [15:0] cc_q [4];
  logic aux_ah_q;
  logic [31:0] pulse_threshold_q;
  wire logic [11:0] cal_off = reg_addr - CAL_BASE;
  wire logic cal_hit = (reg_addr >= CAL_BASE) && (cal_off < 12'h018) && (cal_off[2:0] < 3'h6);
  wire logic [1:0] cal_ph = cal_off[4:3];
  wire logic thr_hit = (reg_addr >= THR_BASE) && (reg_addr < THR_BASE + 12'h006);
  wire logic cc_hit = (reg_addr >= COEFF_BASE) && (reg_addr < COEFF_BASE + 12'h004);
  wire logic [2:0] thr_sel = 3'(reg_addr - THR_BASE);
  wire logic [1:0] cc_sel = 2'(reg_addr - COEFF_BASE);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NPH; p++) begin
        for (int k = 0; k < 6; k++) begin
          cal_q[p][k] <= (k < 3) ? GAIN_UNITY : ZERO16;
        end
      end
      for (int k = 0; k < 6; k++) begin
        thr_q[k] <= ZERO16;
      end
      for (int k = 0; k < 4; k++) begin
        cc_q[k] <= ZERO16;
      end
      aux_ah_q <= 1'b0;
      pulse_threshold_q <= 32'h00000000;
    end else if (reg_wen) begin
      if (cal_hit) begin
        // gains drop the sign bit; offsets keep all 16 bits
        cal_q[cal_ph][cal_off[2:0]] <= (cal_off[2:0] < 3'h3) ?
          (reg_wdata[15:0] & GAIN_MASK) : reg_wdata[15:0];
      end
      if (thr_hit) begin
        thr_q[thr_sel] <= reg_wdata[15:0];
      end
      if (cc_hit) begin
        cc_q[cc_sel] <= reg_wdata[15:0];
      end
      if (reg_addr == MODE_IDX) begin
        aux_ah_q <= reg_wdata[0];
      end
      if (reg_addr == PULSE_THR_IDX) begin
        pulse_threshold_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // per-phase calibration and accumulation
  logic [31:0] vrms_q [NPH];
  logic [31:0] irms_q [NPH];
  logic [31:0] pwr_q [NPH];
  logic [31:0] app_q [NPH];
  logic [ACC_W-1:0] acc_q [NPH][5];
  logic [1:0] rng_q [NPH];
  logic [NPH-1:0] oc_q, ov_q, uv_q, nl_q;
  genvar g;
  generate
    for (g = 0; g < NPH; g++) begin : g_ph
      wire logic [31:0] v_cal, i_cal, p1, p2, p3;
      msc_gain_mul u_v (.val(meas_vrms[g]), .sgn(1'b0), .gain(cal_q[g][MSC_CAL_VGAIN]),
        .res(v_cal));
      msc_gain_mul u_i (.val(meas_irms[g]), .sgn(1'b0), .gain(cal_q[g][MSC_CAL_IGAIN]),
        .res(i_cal));
      // offset point: low range, mid range, else full range
      wire logic [15:0] i_thr = thr_bits(i_cal);
      wire logic [1:0] rng_d = (i_thr < thr_q[THR_RNG_LO]) ? 2'd2 :
                               (i_thr < thr_q[THR_RNG_HI]) ? 2'd1 : 2'd0;
      wire logic [15:0] pa = cal_q[g][3'(MSC_CAL_PA0) + 3'(rng_d)];
      // small-angle rotation: p - q*angle
      wire logic signed [47:0] q_rot = $signed(meas_q[g]) * $signed(pa);
      wire logic [31:0] p_corr = meas_p[g] - q_rot[ANGLE_FRAC +: 32];
      msc_gain_mul u_pv (.val(p_corr), .sgn(1'b1), .gain(cal_q[g][MSC_CAL_VGAIN]), .res(p1));
      msc_gain_mul u_pi (.val(p1), .sgn(1'b1), .gain(cal_q[g][MSC_CAL_IGAIN]), .res(p2));
      msc_gain_mul u_pp (.val(p2), .sgn(1'b1), .gain(cal_q[g][MSC_CAL_PGAIN]),
        .res(p3));
      // volt*amp units carry 2^48; power lsb is 2^32
      wire logic [63:0] va = v_cal * i_cal;
      wire logic [ACC_W-1:0] p_ext = {{(ACC_W-32){pwr_q[g][31]}}, pwr_q[g]};
      wire logic [ACC_W-1:0] s_ext = {{(ACC_W-32){1'b0}}, app_q[g]};
      wire logic [ACC_W-1:0] ah_ext = {{(ACC_W-32-AH_SHIFT){1'b0}}, irms_q[g], {AH_SHIFT{1'b0}}};
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          vrms_q[g] <= 32'h00000000;
          irms_q[g] <= 32'h00000000;
          pwr_q[g] <= 32'h00000000;
          app_q[g] <= 32'h00000000;
          rng_q[g] <= 2'd0;
          for (int k = 0; k < 5; k++) begin
            acc_q[g][k] <= '0;
          end
        end else if (frame_tick) begin
          // refresh every frame, far inside the three-second window
          vrms_q[g] <= v_cal;
          irms_q[g] <= i_cal;
          pwr_q[g] <= p3;
          app_q[g] <= va[VIRT_SHIFT +: 32];
          rng_q[g] <= rng_d;
          // power per frame shifted by 2^16 gives energy lsb
          acc_q[g][EN_ACT] <= acc_q[g][EN_ACT] + p_ext;
          acc_q[g][EN_APP] <= acc_q[g][EN_APP] + s_ext;
          if (pwr_q[g][31]) begin
            acc_q[g][EN_NEG] <= acc_q[g][EN_NEG] - p_ext;
          end else begin
            acc_q[g][EN_POS] <= acc_q[g][EN_POS] + p_ext;
          end
          acc_q[g][EN_AUX] <= acc_q[g][EN_AUX] + (aux_ah_q ? ah_ext : s_ext);
        end
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          oc_q[g] <= 1'b0;
          ov_q[g] <= 1'b0;
          uv_q[g] <= 1'b0;
          nl_q[g] <= 1'b0;
        end else if (frame_tick) begin
          oc_q[g] <= thr_bits(irms_q[g]) > thr_q[THR_OC];
          ov_q[g] <= thr_bits(vrms_q[g]) > thr_q[THR_OV];
          uv_q[g] <= !(thr_bits(vrms_q[g]) > thr_q[THR_UV]);
          nl_q[g] <= thr_bits(irms_q[g]) < thr_q[THR_NO_LOAD_THRESHOLD];
        end
      end
    end
  endgenerate
  assign over_current = oc_q;
  assign over_voltage = ov_q;
  assign under_voltage = uv_q;
  assign no_load = nl_q;

  // ==========================================================
  // read decode
  wire logic [11:0] en_off = reg_addr - ENERGY_BASE;
  wire logic [1:0] en_ph = en_off[4:3];
  wire logic en_hit = (reg_addr >= ENERGY_BASE) && (en_off < 12'h018) && (en_off[2:0] < 3'h5);
  wire logic [1:0] vv = 2'(reg_addr - VIRT_V_BASE);
  wire logic [1:0] vi = 2'(reg_addr - VIRT_I_BASE);
  wire logic [1:0] vp = 2'(reg_addr - VIRT_P_BASE);
  wire logic [1:0] vs = 2'(reg_addr - VIRT_S_BASE);
  wire logic [1:0] vep = 2'(reg_addr - VIRT_EP_BASE);
  wire logic [1:0] ves = 2'(reg_addr - VIRT_ES_BASE);
  wire logic [1:0] rv = 2'(reg_addr - VRMS_RAW_BASE);
  wire logic [1:0] ri = 2'(reg_addr - IRMS_RAW_BASE);
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h00000000;
    if (cal_hit) begin
      rd_d = {16'h0000, cal_q[cal_ph][cal_off[2:0]]};
    end else if (thr_hit) begin
      rd_d = {16'h0000, thr_q[thr_sel]};
    end else if (cc_hit) begin
      rd_d = {16'h0000, cc_q[cc_sel]};
    end else if (en_hit) begin
      rd_d = acc_q[en_ph][en_off[2:0]][ACC_FRAC +: 32];
    end else if (reg_addr == STATUS_IDX) begin
      rd_d = {20'h00000, nl_q, uv_q, ov_q, oc_q};
    end else if (reg_addr == MODE_IDX) begin
      rd_d = {31'h0, aux_ah_q};
    end else if (reg_addr == PULSE_THR_IDX) begin
      rd_d = pulse_threshold_q;
    end else if (rv < 2'd3 && reg_addr >= VRMS_RAW_BASE && reg_addr < VRMS_RAW_BASE + 12'h003) begin
      rd_d = vrms_q[rv];
    end else if (ri < 2'd3 && reg_addr >= IRMS_A_RAW && reg_addr < IRMS_RAW_BASE + 12'h003) begin
      rd_d = irms_q[ri];
    end else if (reg_addr >= VIRT_V_BASE && reg_addr < VIRT_V_BASE + 12'h003) begin
      rd_d = virt_scale(vrms_q[vv], cc_q[CC_VOLT]);
    end else if (reg_addr >= IRMS_A_VIRT && reg_addr < VIRT_I_BASE + 12'h003) begin
      rd_d = virt_scale(irms_q[vi], cc_q[CC_AMP]);
    end else if (reg_addr >= VIRT_P_BASE && reg_addr < VIRT_P_BASE + 12'h003) begin
      rd_d = virt_scale(pwr_q[vp], cc_q[CC_PWR]);
    end else if (reg_addr >= VIRT_S_BASE && reg_addr < VIRT_S_BASE + 12'h003) begin
      rd_d = virt_scale(app_q[vs], cc_q[CC_PWR]);
    end else if (reg_addr >= VIRT_EP_BASE && reg_addr < VIRT_EP_BASE + 12'h003) begin
      rd_d = virt_scale(acc_q[vep][EN_ACT][ACC_FRAC +: 32], cc_q[CC_ENR]);
    end else if (reg_addr >= VIRT_ES_BASE && reg_addr < VIRT_ES_BASE + 12'h003) begin
      rd_d = virt_scale(acc_q[ves][EN_APP][ACC_FRAC +: 32], cc_q[CC_ENR]);
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_ren;
      if (reg_ren) begin
        reg_rdata <= rd_d;
      end
    end
  end
endmodule

/* include/msc_pkg.sv */
// Purpose: constants for the meter-unit scaling and calibration datapath
// Assumes: 50 MHz core clock, three phases, word-indexed register port
// Notes: offsets are register indices on the word-indexed register port
package msc_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned FRAME_PERIOD_NS = 320000;
  localparam int unsigned FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  // ==========================================================
  // widths and fixed-point layout
  localparam int unsigned NPH = 3;
  localparam int unsigned GAIN_FRAC = 14;
  localparam int unsigned ANGLE_FRAC = 16;
  localparam int unsigned VIRT_SHIFT = 16;
  localparam int unsigned THR_LSB = 8;
  localparam int unsigned THR_MSB = 23;
  localparam int unsigned ACC_W = 48;
  localparam int unsigned ACC_FRAC = 16;
  localparam int unsigned AH_SHIFT = 8;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [15:0] GAIN_MASK = 16'h7FFF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // ==========================================================
  // register indices
  localparam logic [11:0] IRMS_A_RAW = 12'h1CC;
  localparam logic [11:0] IRMS_RAW_BASE = 12'h1CC;
  localparam logic [11:0] VRMS_RAW_BASE = 12'h1C4;
  localparam logic [11:0] CAL_BASE = 12'h100;
  localparam logic [11:0] THR_BASE = 12'h040;
  localparam logic [11:0] STATUS_IDX = 12'h050;
  localparam logic [11:0] MODE_IDX = 12'h051;
  localparam logic [11:0] PULSE_THR_IDX = 12'h052;
  localparam logic [11:0] ENERGY_BASE = 12'h200;
  localparam logic [11:0] COEFF_BASE = 12'h800;
  localparam logic [11:0] VIRT_V_BASE = 12'h821;
  localparam logic [11:0] IRMS_A_VIRT = 12'h831;
  localparam logic [11:0] VIRT_I_BASE = 12'h831;
  localparam logic [11:0] VIRT_P_BASE = 12'h841;
  localparam logic [11:0] VIRT_S_BASE = 12'h844;
  localparam logic [11:0] VIRT_EP_BASE = 12'h851;
  localparam logic [11:0] VIRT_ES_BASE = 12'h854;
  // calibration slot within a phase (stride 8)
  typedef enum logic [2:0] {
    MSC_CAL_VGAIN = 3'h0,
    MSC_CAL_IGAIN = 3'h1,
    MSC_CAL_PGAIN = 3'h2,
    MSC_CAL_PA0 = 3'h3,
    MSC_CAL_PA1 = 3'h4,
    MSC_CAL_PA2 = 3'h5
  } msc_cal_t;
  // threshold slots
  localparam logic [2:0] THR_OC = 3'h0;
  localparam logic [2:0] THR_NO_LOAD_THRESHOLD = 3'h1;
  localparam logic [2:0] THR_RNG_LO = 3'h2;
  localparam logic [2:0] THR_RNG_HI = 3'h3;
  localparam logic [2:0] THR_OV = 3'h4;
  localparam logic [2:0] THR_UV = 3'h5;
  // coefficient slots
  localparam logic [1:0] CC_VOLT = 2'h0;
  localparam logic [1:0] CC_AMP = 2'h1;
  localparam logic [1:0] CC_PWR = 2'h2;
  localparam logic [1:0] CC_ENR = 2'h3;
  // energy slots (stride 8 per phase)
  localparam logic [2:0] EN_ACT = 3'h0;
  localparam logic [2:0] EN_APP = 3'h1;
  localparam logic [2:0] EN_POS = 3'h2;
  localparam logic [2:0] EN_NEG = 3'h3;
  localparam logic [2:0] EN_AUX = 3'h4;
endpackage

/* hw/msc_gain_mul.sv */
// Purpose: multiply a 32-bit value by an unsigned 1.14 gain
// Assumes: gain bit 15 already cleared
// Notes: combinational; result truncated to 32 bits
`timescale 1ns/1ps
module msc_gain_mul import msc_pkg::*; (
  input wire logic [31:0] val,
  input wire logic sgn,
  input wire logic [15:0] gain,
  output logic [31:0] res
);
  // ==========================================================
  // datapath
  wire logic signed [32:0] op_s = {sgn & val[31], val};
  wire logic signed [16:0] g_s = {1'b0, gain};
  wire logic signed [49:0] prod = op_s * g_s;
  // gain < 2 keeps the product inside 32 bits for in-range inputs
  assign res = prod[GAIN_FRAC +: 32];
endmodule

/* verification/msc_scale_cal_monitor.sv */
// Purpose: port checker for the scaling datapath
// Assumes: FRAME_LEN equals that of the bound instance
// Notes: flags, frame tick spacing and read port only; arithmetic is left to the bench
`timescale 1ns/1ps
module msc_scale_cal_monitor import msc_pkg::*; #(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_ren,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic frame_tick,
  input wire logic [NPH-1:0] over_current,
  input wire logic [NPH-1:0] over_voltage,
  input wire logic [NPH-1:0] under_voltage,
  input wire logic [NPH-1:0] no_load
);
  // ==========================================================
  // helper: cycles since last tick
  int unsigned gap_q;
  logic seen_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= frame_tick ? 0 : gap_q + 1;
      seen_q <= seen_q | frame_tick;
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_read_req;
    reg_ren;
  endsequence
  sequence s_read_ans;
    reg_rvalid;
  endsequence
  read_answer_a: assert property (s_read_req |=> s_read_ans)
    else $error("read got no answer");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_ren))
    else $error("answer without read");
  rdata_hold_a: assert property ($changed(reg_rdata) |-> reg_rvalid)
    else $error("read data moved without answer");
  frame_period_a: assert property (seen_q |-> frame_tick == (gap_q == FRAME_LEN - 1))
    else $error("frame tick spacing wrong");
  flag_update_a: assert property ($changed({over_voltage, under_voltage}) |-> $past(frame_tick))
    else $error("flag moved off frame tick");
  status_mirror_a: assert property (reg_rvalid && $past(reg_addr) == STATUS_IDX |->
    reg_rdata[11:0] == {$past(no_load), $past(under_voltage), $past(over_voltage),
    $past(over_current)})
    else $error("status differs from flags");
  unmapped_zero_a: assert property (reg_rvalid && $past(reg_addr) == 12'hFFF |-> reg_rdata == 0)
    else $error("unmapped read not zero");
  gain_msb_a: assert property (reg_rvalid && $past(reg_addr[11:8]) == 4'h1
    && $past(reg_addr[2:0]) < 3'h3 |-> reg_rdata[31:15] == 17'h00000)
    else $error("gain msb set");
  reset_clear_a: assert property ($fell(rst) |-> !reg_rvalid && over_voltage == 0)
    else $error("reset left outputs set");
endmodule
bind msc_scale_cal msc_scale_cal_monitor #(.FRAME_LEN(FRAME_LEN)) u_mon (.core_clk(core_clk),
  .rst(rst), .reg_addr(reg_addr), .reg_ren(reg_ren), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .frame_tick(frame_tick), .over_current(over_current),
  .over_voltage(over_voltage), .under_voltage(under_voltage), .no_load(no_load));

/* verification/msc_host_model.sv */
// Purpose: host controller on the register port
// Assumes: called only after reset release
// Notes: keeps calibration words to reload them after a reset
`timescale 1ns/1ps
module msc_host_model import msc_pkg::*; #(
  parameter int unsigned FRAME_LEN = 20
) (
  input wire logic core_clk,
  output logic [11:0] reg_addr,
  output logic reg_wen,
  output logic reg_ren,
  output logic [31:0] reg_wdata,
  input wire logic reg_rvalid
);
  logic [31:0] nv_store [logic [11:0]];
  initial begin
    reg_addr = 12'h000;
    reg_wen = 1'b0;
    reg_ren = 1'b0;
    reg_wdata = 32'h0;
  end
  // raw write, may break the gain msb on purpose
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wen <= 1'b1;
    @(posedge core_clk);
    reg_wen <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (a[11:8] == 4'h1 && a[2:0] < 3'h3) v = d & {16'h0000, GAIN_MASK};
    if (a[11:8] == 4'h1) nv_store[a] = v;
    put(a, v);
  endtask
  task automatic reload();
    foreach (nv_store[k]) put(k, nv_store[k]);
  endtask
  // wait before rereading; frames stand in for seconds
  task automatic settle();
    repeat (3 * FRAME_LEN) @(posedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge core_clk);
    reg_addr <= a;
    reg_ren <= 1'b1;
    @(posedge core_clk);
    reg_ren <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 8);
  endtask
endmodule

/* verification/test_meter_unit_scaling_calibration.sv */
// Purpose: self-checking bench for the scaling datapath
// Assumes: short frames so gains settle quickly
// Notes: a missing answer leaves a note queued and fails the run
`timescale 1ns/1ps
module test_meter_unit_scaling_calibration import msc_pkg::*; ;
  localparam int unsigned FL = 20;
  logic core_clk = 1'b0;
  logic rst;
  logic [11:0] reg_addr;
  logic reg_wen;
  logic reg_ren;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [31:0] meas_vrms [NPH];
  logic [31:0] meas_irms [NPH];
  logic [31:0] meas_p [NPH];
  logic [31:0] meas_q [NPH];
  logic [31:0] exp_q [$];
  logic [31:0] v;
  logic [31:0] i;
  logic [31:0] p;
  logic [63:0] s;
  logic [31:0] t;
  logic signed [63:0] r;
  logic tick;
  int n_tick = 0;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h8D01;
  always #10 core_clk = ~core_clk;
  msc_host_model #(.FRAME_LEN(FL)) host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wen(reg_wen), .reg_ren(reg_ren), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid));
  msc_scale_cal #(.FRAME_LEN(FL)) DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wen(reg_wen), .reg_ren(reg_ren), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .meas_vrms(meas_vrms), .meas_irms(meas_irms), .meas_p(meas_p),
    .meas_q(meas_q), .frame_tick(tick), .over_current(), .over_voltage(), .under_voltage(),
    .no_load());
  task automatic compare_word(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, want);
    end
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic finish_test();
    if (exp_q.size() != 0) n_mismatch++;
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // answers are taken oldest note first
  always @(posedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() > 0) begin
        compare_word(reg_rdata, exp_q.pop_front());
      end else begin
        comparisons++;
        n_mismatch++;
        $display("wrong value at %0t: answer without a read", $time);
      end
    end
  end
  // frames seen by the accumulators, cleared with them
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      n_tick <= 0;
    end else if (tick === 1'b1) begin
      n_tick <= n_tick + 1;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("wrong value at %0t: run timed out", $time);
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    v = ($random(seed) & 32'h007FFFFF) | 32'h00800000;
    i = 32'h007654AF;
    p = $random(seed) & 32'h003FFFFC;
    s = (64'(v) * 64'(i)) >> 16;
    for (int k = 0; k < NPH; k++) begin
      meas_vrms[k] = v;
      meas_irms[k] = i;
      meas_p[k] = p;
      meas_q[k] = $random(seed);
    end
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    chk(CAL_BASE, {16'h0000, GAIN_UNITY});
    chk(COEFF_BASE, 32'h0);
    chk(12'hFFF, 32'h0);
    host.wr(12'h801, 32'h190);
    host.wr(12'h802, 32'h1);
    host.settle();
    chk(IRMS_A_RAW, i);
    chk(IRMS_A_VIRT, 32'hB8E45170);
    chk(IRMS_A_RAW, i);
    chk(VRMS_RAW_BASE, v);
    chk(VIRT_S_BASE, s[31:0]);
    chk(VIRT_P_BASE, p);
    chk(VIRT_V_BASE, 32'h0);
    host.put(CAL_BASE, 32'h0000A000);
    chk(CAL_BASE, 32'h2000);
    host.wr(12'h102, 32'h2000);
    host.settle();
    chk(VRMS_RAW_BASE, v >> 1);
    chk(VIRT_P_BASE, p >> 2);
    host.wr(CAL_BASE, 32'h4000);
    host.wr(THR_BASE + 12'h4, {16'h0000, v[23:8] - 16'h0001});
    host.wr(THR_BASE + 12'h5, 32'hFFFF);
    host.wr(THR_BASE, 32'hFFFF);
    host.wr(THR_BASE + 12'h1, 32'h100);
    host.settle();
    chk(STATUS_IDX, 32'h1F8);
    host.wr(THR_BASE + 12'h4, {16'h0000, v[23:8]});
    host.settle();
    chk(STATUS_IDX, 32'h1C0);
    t = $random(seed);
    host.wr(PULSE_THR_IDX, t);
    chk(PULSE_THR_IDX, t);
    // low range limit above the current picks the third offset point
    host.wr(12'h10D, 32'h0260);
    host.wr(THR_BASE + 12'h2, 32'h8000);
    host.settle();
    r = $signed(meas_q[1]) * $signed(16'h0260);
    chk(VIRT_P_BASE + 12'h001, p - r[47:16]);
    host.wr(THR_BASE + 12'h2, 32'h0);
    host.settle();
    chk(VIRT_P_BASE + 12'h001, p);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    chk(12'h102, {16'h0000, GAIN_UNITY});
    chk(THR_BASE + 12'h4, 32'h0);
    host.reload();
    chk(12'h102, 32'h2000);
    host.wr(MODE_IDX, 32'h1);
    repeat (3) @(posedge core_clk iff tick === 1'b1);
    @(negedge core_clk);
    // first frame after reset adds the cleared latches
    chk(ENERGY_BASE + 12'h014, 32'((64'(n_tick - 1) * 64'(i)) >> 8));
    chk(ENERGY_BASE + 12'h010, 32'((64'(n_tick - 1) * 64'(p)) >> 16));
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule
